/* core/monitor_map_defines.vh */
// Purpose: constants for the current monitor output mapper
// Assumes: sys_clk at 25 MHz; currents and full scale in femtoamperes
// Notes: dac code +/-32767 stands for +/-10 V on the analog monitor
// Contract
// - drive analog and frequency monitors together
// - frequency output is a 50% square wave
// - unit scale maps full scale to +/-10 V
// - frequency spans zero to selected maximum
// - five maxima, 100 Hz to 1 MHz
// - magnitude mapping uses absolute current
// - positive mapping, negatives give zero
// - negative mapping, positives give zero
// - linear volts are 10*I/(F*Ifs)
// - scale factor applies; ceiling 1 MHz
// - log option only on analog monitor
// - log volts are log10(|I|)+13, mirrored
// - log mode below 0.1 pA gives 0 V
// - log ignores range and scale factor
`ifndef MONITOR_MAP_DEFINES_VH
`define MONITOR_MAP_DEFINES_VH

// register byte offsets
`define REG_CTRL 8'h00
`define REG_SCALE 8'h04
`define REG_STATUS 8'h08
`define REG_DAC 8'h0c
`define REG_FREQ 8'h10
`define REG_HALF 8'h14

// control fields
`define CTRL_LOG 0
`define CTRL_MAP_LO 1
`define CTRL_MAP_HI 2
`define CTRL_FSEL_LO 3
`define CTRL_FSEL_HI 5
`define MAP_MAG 2'h0
`define MAP_POS 2'h1
`define MAP_NEG 2'h2

// reset values; scale is unsigned 16.16, 1.00 at reset
`define SCALE_RESET 32'h0001_0000
`define SCALE_FRAC_BITS 16

// analog code and frequency figures
`define VMAX_CODE 16'h7fff
`define FMAX_100HZ 20'h0_0064
`define FMAX_1KHZ 20'h0_03e8
`define FMAX_10KHZ 20'h0_2710
`define FMAX_100KHZ 20'h1_86a0
`define FMAX_1MHZ 20'hf_4240
`define FREQ_CEIL 20'hf_4240

// clock rate in Hz and the half period numerator derived from it
`define CLK_HZ 72'h17d_7840
`define HALF_NUM (`CLK_HZ >> 1)
`define DIV_STEPS 7'h48

// log mapping: code = (log2_q8 * slope >> shift) - offset, for |I| in fA
`define LOG_MIN_FA 48'h0000_0000_0064
`define LOG_SLOPE 26'h000_0f6a
`define LOG_SHIFT 10
`define LOG_OFFSET 16'h1999

`endif

/* core/current_monitor_output_mapper.v */
// Purpose: map the newest current reading onto an analog dac code and a square wave
// Assumes: readings arrive on sys_clk as signed femtoamperes with full scale
// Notes: one shared serial divider does voltage, frequency and half period
//
// The register offsets and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "monitor_map_defines.vh"

module current_monitor_output_mapper (
   // clock and reset
   input wire sys_clk,
   input wire rst,
   // avalon-mm register slave
   input wire [7:0] avs_address,
   input wire avs_read,
   input wire avs_write,
   input wire [31:0] avs_writedata,
   input wire [3:0] avs_byteenable,
   output wire [31:0] avs_readdata,
   output wire avs_waitrequest,
   // measured current from the integrator logic
   input wire meas_valid,
   input wire [47:0] meas_current,
   input wire [47:0] meas_full_scale,
   // monitor outputs
   output wire [15:0] dac_code,
   output wire dac_load,
   output wire freq_out
);

   localparam ST_IDLE = 3'h0;
   localparam ST_LOAD_V = 3'h1;
   localparam ST_WAIT_V = 3'h2;
   localparam ST_LOAD_F = 3'h3;
   localparam ST_WAIT_F = 3'h4;
   localparam ST_LOAD_H = 3'h5;
   localparam ST_WAIT_H = 3'h6;
   localparam ST_DONE = 3'h7;

   // register file
   reg log_q;
   reg [1:0] map_q;
   reg [2:0] fsel_q;
   reg [31:0] scale_q;
   reg ack_q;
   reg [31:0] rdata_q;

   // newest reading waiting for the pipeline
   reg pend_q;
   reg [47:0] hold_cur_q;
   reg [47:0] hold_fs_q;

   // snapshot of one reading and its settings
   reg cap_neg_q;
   reg [47:0] cap_mag_q;
   reg [47:0] cap_fs_q;
   reg [31:0] cap_scale_q;
   reg cap_log_q;
   reg [1:0] cap_map_q;
   reg [2:0] cap_fsel_q;

   // sequencer and divider
   reg [2:0] state_q;
   reg [71:0] div_num_q;
   reg [63:0] div_den_q;
   reg [64:0] div_rem_q;
   reg [6:0] div_cnt_q;
   reg [15:0] v_res_q;
   reg v_sat_q;
   reg [19:0] f_res_q;
   reg f_sat_q;
   reg [23:0] h_res_q;

   // published results
   reg [15:0] dac_code_q;
   reg dac_load_q;
   reg [19:0] freq_hz_q;
   reg [23:0] half_pub_q;

   // square wave generator
   reg [23:0] sq_half_q;
   reg [23:0] sq_cnt_q;
   reg sq_out_q;

   wire access;
   wire take;
   wire [47:0] cur_abs;
   wire [79:0] den_full;
   wire [71:0] num_v;
   wire [71:0] num_f;
   wire [64:0] rem_sh;
   wire rem_ge;
   wire [64:0] rem_nx;
   reg [47:0] sel_mag;
   reg [19:0] fmax_sel;
   reg [5:0] lo_pos;
   reg [47:0] norm;
   reg [25:0] log_prod;
   reg [15:0] log_code;
   integer i;

   function [31:0] merge_bytes;
      input [31:0] old_val;
      input [31:0] new_val;
      input [3:0] be;
      integer b;
      begin
         merge_bytes = old_val;
         for (b = 0; b < 4; b = b + 1) begin
            if (be[b]) begin
               merge_bytes[b*8 +: 8] = new_val[b*8 +: 8];
            end
         end
      end
   endfunction

   // avalon: one wait cycle, answer on the second edge of a request
   assign access = avs_read | avs_write;
   assign avs_waitrequest = access & ~ack_q;
   assign take = access & ack_q;
   assign avs_readdata = rdata_q;

   always @(posedge sys_clk) begin
      if (rst) begin
         ack_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
         log_q <= 1'b0;
         map_q <= `MAP_MAG;
         fsel_q <= 3'h4;
         scale_q <= `SCALE_RESET;
      end else begin
         ack_q <= access & ~ack_q;
         if (avs_read & ~ack_q) begin
            case (avs_address)
               `REG_CTRL: begin
                  rdata_q <= {26'h000_0000, fsel_q, map_q, log_q};
               end
               `REG_SCALE: begin
                  rdata_q <= scale_q;
               end
               `REG_STATUS: begin
                  rdata_q <= {28'h000_0000, pend_q, f_sat_q, v_sat_q, state_q != ST_IDLE};
               end
               `REG_DAC: begin
                  rdata_q <= {16'h0000, dac_code_q};
               end
               `REG_FREQ: begin
                  rdata_q <= {12'h000, freq_hz_q};
               end
               `REG_HALF: begin
                  rdata_q <= {8'h00, half_pub_q};
               end
               default: begin
                  rdata_q <= 32'h0000_0000;
               end
            endcase
         end
         // settings are held here and sampled once per reading
         if (take & avs_write) begin
            if (avs_address == `REG_CTRL && avs_byteenable[0]) begin
               log_q <= avs_writedata[`CTRL_LOG];
               map_q <= avs_writedata[`CTRL_MAP_HI:`CTRL_MAP_LO];
               fsel_q <= avs_writedata[`CTRL_FSEL_HI:`CTRL_FSEL_LO];
            end
            if (avs_address == `REG_SCALE) begin
               scale_q <= merge_bytes(scale_q, avs_writedata, avs_byteenable);
            end
         end
      end
   end

   // arithmetic on the held reading and the snapshot
   assign cur_abs = hold_cur_q[47] ? (~hold_cur_q + 48'h0000_0000_0001) : hold_cur_q;
   assign den_full = {32'h0000_0000, cap_fs_q} * {48'h0000_0000_0000, cap_scale_q};
   assign num_v = {24'h00_0000, cap_mag_q} * {56'h00_0000_0000_0000, `VMAX_CODE};
   assign num_f = {24'h00_0000, sel_mag} * {52'h0_0000_0000_0000, fmax_sel};

   always @* begin
      case (cap_map_q)
         `MAP_POS: sel_mag = cap_neg_q ? 48'h0000_0000_0000 : cap_mag_q;
         `MAP_NEG: sel_mag = cap_neg_q ? cap_mag_q : 48'h0000_0000_0000;
         default: sel_mag = cap_mag_q;
      endcase
      case (cap_fsel_q)
         3'h0: fmax_sel = `FMAX_100HZ;
         3'h1: fmax_sel = `FMAX_1KHZ;
         3'h2: fmax_sel = `FMAX_10KHZ;
         3'h3: fmax_sel = `FMAX_100KHZ;
         default: fmax_sel = `FMAX_1MHZ;
      endcase
   end

   // log path: log2 from leading one plus eight mantissa bits, no range or scale
   always @* begin
      lo_pos = 6'h00;
      for (i = 0; i < 48; i = i + 1) begin
         if (cap_mag_q[i]) begin
            lo_pos = i[5:0];
         end
      end
      norm = cap_mag_q << (6'd47 - lo_pos);
      log_prod = {12'h000, lo_pos, norm[46:39]} * `LOG_SLOPE;
      log_code = 16'h0000;
      if (cap_mag_q < `LOG_MIN_FA) begin
         log_code = 16'h0000;
      end else if (log_prod[25:`LOG_SHIFT] > {`VMAX_CODE + `LOG_OFFSET}) begin
         log_code = `VMAX_CODE;
      end else if (log_prod[25:`LOG_SHIFT] > {1'b0, `LOG_OFFSET}) begin
         log_code = log_prod[25:`LOG_SHIFT] - `LOG_OFFSET;
      end
   end

   // restoring divider, one quotient bit per clock
   assign rem_sh = {div_rem_q[63:0], div_num_q[71]};
   assign rem_ge = rem_sh >= {1'b0, div_den_q};
   assign rem_nx = rem_ge ? (rem_sh - {1'b0, div_den_q}) : rem_sh;

   always @(posedge sys_clk) begin
      if (rst) begin
         pend_q <= 1'b0;
         hold_cur_q <= 48'h0000_0000_0000;
         hold_fs_q <= 48'h0000_0000_0000;
         cap_neg_q <= 1'b0;
         cap_mag_q <= 48'h0000_0000_0000;
         cap_fs_q <= 48'h0000_0000_0000;
         cap_scale_q <= `SCALE_RESET;
         cap_log_q <= 1'b0;
         cap_map_q <= `MAP_MAG;
         cap_fsel_q <= 3'h4;
         state_q <= ST_IDLE;
         div_num_q <= 72'h00_0000_0000_0000_0000;
         div_den_q <= 64'h0000_0000_0000_0000;
         div_rem_q <= 65'h0_0000_0000_0000_0000;
         div_cnt_q <= 7'h00;
         v_res_q <= 16'h0000;
         v_sat_q <= 1'b0;
         f_res_q <= 20'h0_0000;
         f_sat_q <= 1'b0;
         h_res_q <= 24'h00_0000;
         dac_code_q <= 16'h0000;
         dac_load_q <= 1'b0;
         freq_hz_q <= 20'h0_0000;
         half_pub_q <= 24'h00_0000;
      end else begin
         dac_load_q <= 1'b0;
         if (div_cnt_q != 7'h00) begin
            div_num_q <= {div_num_q[70:0], rem_ge};
            div_rem_q <= rem_nx;
            div_cnt_q <= div_cnt_q - 7'h01;
         end
         // a reading that lands while the previous one is taken still counts
         if (meas_valid) begin
            hold_cur_q <= meas_current;
            hold_fs_q <= meas_full_scale;
         end
         if (meas_valid) begin
            pend_q <= 1'b1;
         end else if (state_q == ST_IDLE && pend_q) begin
            pend_q <= 1'b0;
         end
         case (state_q)
            ST_IDLE: begin
               if (pend_q) begin
                  cap_neg_q <= hold_cur_q[47];
                  cap_mag_q <= cur_abs;
                  cap_fs_q <= hold_fs_q;
                  cap_scale_q <= scale_q;
                  cap_log_q <= log_q;
                  cap_map_q <= map_q;
                  cap_fsel_q <= fsel_q;
                  state_q <= ST_LOAD_V;
               end
            end
            ST_LOAD_V: begin
               if (cap_log_q) begin
                  v_res_q <= log_code;
                  v_sat_q <= (log_code == `VMAX_CODE);
                  state_q <= ST_LOAD_F;
               end else begin
                  div_num_q <= num_v;
                  div_den_q <= den_full[79:`SCALE_FRAC_BITS];
                  div_rem_q <= 65'h0_0000_0000_0000_0000;
                  div_cnt_q <= `DIV_STEPS;
                  state_q <= ST_WAIT_V;
               end
            end
            ST_WAIT_V: begin
               if (div_cnt_q == 7'h00) begin
                  if (div_num_q > {56'h00_0000_0000_0000, `VMAX_CODE}) begin
                     v_res_q <= `VMAX_CODE;
                     v_sat_q <= 1'b1;
                  end else begin
                     v_res_q <= div_num_q[15:0];
                     v_sat_q <= 1'b0;
                  end
                  state_q <= ST_LOAD_F;
               end
            end
            ST_LOAD_F: begin
               if (sel_mag == 48'h0000_0000_0000) begin
                  f_res_q <= 20'h0_0000;
                  f_sat_q <= 1'b0;
                  h_res_q <= 24'h00_0000;
                  state_q <= ST_DONE;
               end else begin
                  // frequency is always linear and uses the scale factor
                  div_num_q <= num_f;
                  div_den_q <= den_full[79:`SCALE_FRAC_BITS];
                  div_rem_q <= 65'h0_0000_0000_0000_0000;
                  div_cnt_q <= `DIV_STEPS;
                  state_q <= ST_WAIT_F;
               end
            end
            ST_WAIT_F: begin
               if (div_cnt_q == 7'h00) begin
                  if (div_num_q > {52'h0_0000_0000_0000, `FREQ_CEIL}) begin
                     f_res_q <= `FREQ_CEIL;
                     f_sat_q <= 1'b1;
                     state_q <= ST_LOAD_H;
                  end else if (div_num_q == 72'h00_0000_0000_0000_0000) begin
                     f_res_q <= 20'h0_0000;
                     f_sat_q <= 1'b0;
                     h_res_q <= 24'h00_0000;
                     state_q <= ST_DONE;
                  end else begin
                     f_res_q <= div_num_q[19:0];
                     f_sat_q <= 1'b0;
                     state_q <= ST_LOAD_H;
                  end
               end
            end
            ST_LOAD_H: begin
               div_num_q <= `HALF_NUM;
               div_den_q <= {44'h000_0000_0000, f_res_q};
               div_rem_q <= 65'h0_0000_0000_0000_0000;
               div_cnt_q <= `DIV_STEPS;
               state_q <= ST_WAIT_H;
            end
            ST_WAIT_H: begin
               // round the half period up so the ceiling is never passed
               if (div_cnt_q == 7'h00) begin
                  if (div_rem_q != 65'h0_0000_0000_0000_0000) begin
                     h_res_q <= div_num_q[23:0] + 24'h00_0001;
                  end else begin
                     h_res_q <= div_num_q[23:0];
                  end
                  state_q <= ST_DONE;
               end
            end
            ST_DONE: begin
               // both monitors are published in the same cycle
               dac_code_q <= cap_neg_q ? (~v_res_q + 16'h0001) : v_res_q;
               dac_load_q <= 1'b1;
               freq_hz_q <= f_res_q;
               half_pub_q <= h_res_q;
               state_q <= ST_IDLE;
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // square wave: a new half period is taken only at the end of a low phase or while stopped,
   // so every cycle has equal high and low halves
   always @(posedge sys_clk) begin
      if (rst) begin
         sq_half_q <= 24'h00_0000;
         sq_cnt_q <= 24'h00_0000;
         sq_out_q <= 1'b0;
      end else if (sq_half_q == 24'h00_0000) begin
         sq_out_q <= 1'b0;
         sq_cnt_q <= 24'h00_0000;
         sq_half_q <= half_pub_q;
      end else if (sq_cnt_q == sq_half_q - 24'h00_0001) begin
         sq_cnt_q <= 24'h00_0000;
         if (sq_out_q) begin
            sq_out_q <= 1'b0;
         end else begin
            sq_half_q <= half_pub_q;
            sq_out_q <= (half_pub_q != 24'h00_0000);
         end
      end else begin
         sq_cnt_q <= sq_cnt_q + 24'h00_0001;
      end
   end

   assign dac_code = dac_code_q;
   assign dac_load = dac_load_q;
   assign freq_out = sq_out_q;

endmodule

/* test/mapper_monitor.sv */
// Purpose: concurrent checks on the port behaviour of the monitor output mapper
// Assumes: one sys_clk domain, rst synchronous active high
// Notes: duty check is one-sided so a restart from an idle low level cannot fire it
`timescale 1ns/1ps
module mapper_monitor (
   // clock and reset
   input wire sys_clk,
   input wire rst,
   // register bus
   input wire avs_read,
   input wire avs_write,
   input wire avs_waitrequest,
   // reading and monitors
   input wire meas_valid,
   input wire [15:0] dac_code,
   input wire dac_load,
   input wire freq_out
);
   reg prev_q;
   reg seen_q;
   reg [31:0] cnt_q;
   reg [31:0] hi_len_q;
   wire toggle = freq_out != prev_q;
   // cnt_q holds the length of the phase that ends in the cycle a toggle is seen
   always @(posedge sys_clk) begin
      if (rst) begin
         prev_q <= 1'b0;
         seen_q <= 1'b0;
         cnt_q <= 32'h0000_0000;
         hi_len_q <= 32'h0000_0000;
      end else begin
         prev_q <= freq_out;
         cnt_q <= toggle ? 32'h0000_0001 : cnt_q + 32'h0000_0001;
         if (prev_q && !freq_out) begin
            hi_len_q <= cnt_q;
            seen_q <= 1'b1;
         end
      end
   end
   sequence req_served_s;
      avs_waitrequest ##1 !avs_waitrequest;
   endsequence
   sequence load_soon_s;
      ##[1:480] dac_load;
   endsequence
   bus_answer_a: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(avs_read || avs_write) |-> req_served_s) else $error("bus answer out of step");
   idle_no_wait_a: assert property (@(posedge sys_clk) disable iff (rst)
      !(avs_read || avs_write) |-> !avs_waitrequest) else $error("wait raised while idle");
   load_single_a: assert property (@(posedge sys_clk) disable iff (rst)
      dac_load |=> !dac_load) else $error("load pulse longer than one cycle");
   code_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
      !dac_load |-> $stable(dac_code)) else $error("dac code moved without load");
   load_bound_a: assert property (@(posedge sys_clk) disable iff (rst)
      meas_valid |-> load_soon_s) else $error("reading not answered in time");
   code_sat_a: assert property (@(posedge sys_clk) disable iff (rst)
      dac_load |-> dac_code != 16'h8000) else $error("dac code beyond negative limit");
   duty_even_a: assert property (@(posedge sys_clk) disable iff (rst)
      (seen_q && !prev_q && freq_out) |-> cnt_q >= hi_len_q) else $error("low phase short");
   half_min_a: assert property (@(posedge sys_clk) disable iff (rst)
      (toggle && (prev_q || seen_q)) |-> cnt_q >= 32'h0000_000d) else $error("phase too short");
   reset_quiet_a: assert property (@(posedge sys_clk) disable iff (rst)
      $fell(rst) |-> dac_code == 16'h0000 && !freq_out && !dac_load)
      else $error("outputs not quiet after reset");
endmodule
bind current_monitor_output_mapper mapper_monitor mapper_monitor_i (.sys_clk(sys_clk),
   .rst(rst), .avs_read(avs_read), .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest), .meas_valid(meas_valid), .dac_code(dac_code),
   .dac_load(dac_load), .freq_out(freq_out));

/* test/counter_card.sv */
// Purpose: far-side counter card and digitizer watching both monitors
// Assumes: sampled on sys_clk; phase lengths counted in clock cycles
// Notes: only observes, the monitors are outputs with nothing driven back
`timescale 1ns/1ps
module counter_card (
   // clock
   input wire sys_clk,
   // monitor lines
   input wire freq_out,
   input wire [15:0] dac_code,
   input wire dac_load,
   // results of the last complete phases and the held sample
   output reg [31:0] hi_cycles,
   output reg [31:0] lo_cycles,
   output reg [15:0] dac_held
);
   reg last_q;
   reg [31:0] run_q;
   initial begin
      last_q = 1'b0;
      run_q = 32'h0000_0000;
      hi_cycles = 32'h0000_0000;
      lo_cycles = 32'h0000_0000;
      dac_held = 16'h0000;
   end
   always @(posedge sys_clk) begin
      last_q <= freq_out;
      run_q <= (freq_out != last_q) ? 32'h0000_0001 : run_q + 32'h0000_0001;
      // counter card times each phase separately
      if (last_q && !freq_out) hi_cycles <= run_q;
      if (!last_q && freq_out) lo_cycles <= run_q;
      // digitizer samples the analog value on each update
      if (dac_load) dac_held <= dac_code;
   end
endmodule

/* test/current_monitor_output_mapper_tb.sv */
// Purpose: register-driven tests of analog and frequency monitor mapping
// Assumes: 25 MHz sys_clk, currents in fA, scale in 16.16
// Notes: slow maxima are checked through FREQ and HALF only, their waves are too long
`timescale 1ns/1ps
`include "monitor_map_defines.vh"
module current_monitor_output_mapper_tb;
   logic sys_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, meas_valid = 1'b0;
   logic [7:0] avs_address = 8'h00;
   logic [31:0] avs_writedata = 32'h0000_0000, rdv;
   logic [3:0] avs_byteenable = 4'hf;
   logic [47:0] meas_current = 48'h0000_0000_0000, meas_full_scale = 48'h0000_0000_0000;
   wire [31:0] avs_readdata, hi_cycles, lo_cycles;
   wire [15:0] dac_code, dac_held;
   wire avs_waitrequest, dac_load, freq_out;
   logic [15:0] code;
   int error_cnt = 0, checks = 0, cycles = 0;
   longint fm[5] = '{100, 1000, 10000, 100000, 1000000};
   longint fs = 1000000;
   current_monitor_output_mapper current_monitor_output_mapper_i (.sys_clk(sys_clk),
      .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .meas_valid(meas_valid), .meas_current(meas_current),
      .meas_full_scale(meas_full_scale), .dac_code(dac_code), .dac_load(dac_load),
      .freq_out(freq_out));
   counter_card counter_card_i (.sys_clk(sys_clk), .freq_out(freq_out), .dac_code(dac_code),
      .dac_load(dac_load), .hi_cycles(hi_cycles), .lo_cycles(lo_cycles), .dac_held(dac_held));
   always #20 sys_clk = ~sys_clk;
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 40000) begin
         error_cnt++;
         tally_and_finish;
      end
   end
   task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask
   // log codes come from a piecewise-linear log, so a small band is accepted
   task automatic cmp_near(input string nm, input int e, input logic [15:0] g);
      checks++;
      if ($isunknown(g) || $signed(g) > e + 100 || $signed(g) < e - 100) begin
         error_cnt++;
         $display("unexpected %s expected %0d seen %h", nm, e, g);
      end
   endtask
   // request held up to the rising edge that samples waitrequest low, data taken there;
   // a hung slave is left to the cycle ceiling
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge sys_clk);
      end while (avs_waitrequest !== 1'b0);
      rdv = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic feed(input logic [31:0] ctl, input logic [31:0] sc, input longint cur,
                       input longint f);
      int n;
      n = 0;
      bus(1'b1, `REG_CTRL, ctl);
      bus(1'b1, `REG_SCALE, sc);
      @(posedge sys_clk);
      meas_current <= 48'(cur);
      meas_full_scale <= 48'(f);
      meas_valid <= 1'b1;
      @(posedge sys_clk);
      meas_valid <= 1'b0;
      @(negedge sys_clk);
      while (dac_load !== 1'b1 && n < 300) begin
         @(negedge sys_clk);
         n++;
      end
      if (n == 300) error_cnt++;
      code = dac_code;
   endtask
   function automatic logic [15:0] exp_code(longint i, longint f, longint s);
      longint den, q;
      den = (s * f) >> 16;
      q = (den == 0) ? 32767 : 32767 * (i < 0 ? -i : i) / den;
      if (q > 32767) q = 32767;
      return 16'(i < 0 ? -q : q);
   endfunction
   function automatic longint exp_freq(longint i, longint s, int mp, int fsel);
      longint sel, q;
      sel = (mp == 1) ? (i > 0 ? i : 0) : (mp == 2) ? (i < 0 ? -i : 0) : (i < 0 ? -i : i);
      q = sel * fm[fsel] / ((s * fs) >> 16);
      return q > 1000000 ? 1000000 : q;
   endfunction
   function automatic logic [31:0] ctrl(int fsel, int mp, int lg);
      return 32'(fsel * 8 + mp * 2 + lg);
   endfunction
   // linear cases: current, scale
   longint lc[5] = '{1000000, -500000, 1000000, 1000000, -2000000};
   longint ls[5] = '{65536, 65536, 32768, 131072, 65536};
   // map cases: map, current
   int mm[5] = '{1, 3, 2, 1, 2};
   longint mc[5] = '{500000, -500000, -500000, -500000, 500000};
   longint fq;
   initial begin
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      bus(1'b0, `REG_CTRL, 0);
      cmp("ctrl reset", 32'h0000_0020, rdv);
      bus(1'b0, `REG_SCALE, 0);
      cmp("scale reset", 32'h0001_0000, rdv);
      bus(1'b1, 8'h20, 32'h1234_5678);
      bus(1'b0, 8'h20, 0);
      cmp("unmapped", 32'h0000_0000, rdv);
      for (int k = 0; k < 5; k++) begin
         feed(ctrl(4, 0, 0), 32'(ls[k]), lc[k], fs);
         cmp("linear code", 32'(exp_code(lc[k], fs, ls[k])), 32'(code));
         @(negedge sys_clk);
         cmp("digitizer", 32'(code), 32'(dac_held));
      end
      bus(1'b0, `REG_DAC, 0);
      cmp("dac register", 32'h0000_8001, rdv);
      for (int k = 0; k < 5; k++) begin
         feed(ctrl(k, 0, 0), 32'h0001_0000, -500000, fs);
         bus(1'b0, `REG_FREQ, 0);
         cmp("freq select", 32'(fm[k] / 2), rdv);
         bus(1'b0, `REG_HALF, 0);
         cmp("half period", 32'((12500000 + fm[k] / 2 - 1) / (fm[k] / 2)), rdv);
      end
      // slow waves keep their half period until a low phase ends, so reset clears them
      @(posedge sys_clk);
      rst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      bus(1'b0, `REG_DAC, 0);
      cmp("dac after reset", 32'h0000_0000, rdv);
      for (int k = 0; k < 5; k++) begin
         feed(ctrl(4, mm[k], 0), 32'h0001_0000, mc[k], fs);
         fq = exp_freq(mc[k], 65536, mm[k] % 3, 4);
         bus(1'b0, `REG_FREQ, 0);
         cmp("map freq", 32'(fq), rdv);
      end
      repeat (300) @(posedge sys_clk);
      cmp("zero freq idle", 32'h0000_0000, 32'(freq_out));
      for (int k = 3; k < 5; k++) begin
         feed(ctrl(k, 0, 0), 32'h0000_8000, fs, fs);
         fq = exp_freq(fs, 32768, 0, k);
         bus(1'b0, `REG_FREQ, 0);
         cmp("scaled freq", 32'(fq), rdv);
      end
      bus(1'b0, `REG_STATUS, 0);
      cmp("status flags", 32'h0000_0006, rdv);
      feed(ctrl(4, 0, 0), 32'h0001_0000, 250000, fs);
      repeat (400) @(posedge sys_clk);
      cmp("high phase", 32'h0000_0032, hi_cycles);
      cmp("low phase", 32'h0000_0032, lo_cycles);
      cmp("analog with wave", 32'(exp_code(250000, fs, 65536)), 32'(dac_held));
      feed(ctrl(4, 0, 1), 32'h0001_0000, 1000000, fs);
      cmp_near("log pos", 13107, code);
      bus(1'b0, `REG_FREQ, 0);
      cmp("log freq linear", 32'h000f_4240, rdv);
      feed(ctrl(4, 0, 1), 32'h0000_8000, 1000000, 64'd8000000);
      cmp_near("log range free", 13107, code);
      feed(ctrl(4, 0, 1), 32'h0001_0000, -1000000000, fs);
      cmp_near("log neg", -22937, code);
      feed(ctrl(4, 0, 1), 32'h0001_0000, -99, fs);
      cmp("log floor", 32'h0000_0000, 32'(code));
      tally_and_finish;
   end
endmodule
